// File: logic/rtcs_defines.vh
// Purpose: shared constants of the reset and start-up sequencer
// Assumes: included by its bare name from every design file
// Notes: counts derived from times are integer expressions
`ifndef RTCS_DEFINES_VH
`define RTCS_DEFINES_VH

// clock_source_select encodings
`define RTCS_MODE_XTAL_DIRECT   2'h0
`define RTCS_MODE_EXT_DIRECT    2'h1
`define RTCS_MODE_XTAL_PLL      2'h2
`define RTCS_MODE_EXT_PLL       2'h3

// register byte offsets
`define RTCS_ADDR_POWER_CONTROL_STATUS          8'h00
`define RTCS_ADDR_STATUS        8'h04
`define RTCS_ADDR_CTRL          8'h08
`define RTCS_ADDR_CAUSE         8'h0c

// field positions
`define RTCS_POWER_CONTROL_STATUS_BOR_BIT       0
`define RTCS_POWER_CONTROL_STATUS_POR_BIT       1
`define RTCS_STAT_RUN_BIT       0
`define RTCS_STAT_RESET_BIT     1
`define RTCS_STAT_PD_BIT        3
`define RTCS_STAT_TO_BIT        4
`define RTCS_CTRL_SLEEP_BIT     0
`define RTCS_CTRL_CLRWDT_BIT    1

// reset values
`define RTCS_TO_RST             1'h1
`define RTCS_PD_RST             1'h1
`define RTCS_POR_FLAG_RST       1'h0

// one-hot reset causes
`define RTCS_CAUSE_POR          5'h01
`define RTCS_CAUSE_MASTER_CLEAR_N_RUN     5'h02
`define RTCS_CAUSE_MASTER_CLEAR_N_SLEEP   5'h04
`define RTCS_CAUSE_WDT          5'h08
`define RTCS_CAUSE_BOR          5'h10

// timing
`define RTCS_CLK_PERIOD_NS      100
`define RTCS_POWER_UP_TIMER_DELAY_MS      72
`define RTCS_RC_TICK_MS         18
`define RTCS_POWER_UP_TIMER_TICKS         (`RTCS_POWER_UP_TIMER_DELAY_MS / `RTCS_RC_TICK_MS)
`define RTCS_PLL_LOCK_TICKS     2
`define RTCS_OST_CYCLES         1024
`define RTCS_MASTER_CLEAR_N_FILT_NS       300
`define RTCS_MASTER_CLEAR_N_FILT_CYCLES   ((`RTCS_MASTER_CLEAR_N_FILT_NS + `RTCS_CLK_PERIOD_NS - 1) / `RTCS_CLK_PERIOD_NS)

`endif

// File: logic/rtcs_glitch_filter.v
// Purpose: master clear noise filter
// Assumes: din synchronous to clk
// Notes: output follows only after din stays steady for the full count
`timescale 1ns/1ns
`include "rtcs_defines.vh"
module rtcs_glitch_filter (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// raw and filtered level
	input  wire din,
	output reg  dout
);

localparam [31:0] STABLE_N = `RTCS_MASTER_CLEAR_N_FILT_CYCLES;
localparam [3:0]  LAST     = STABLE_N[3:0] - 4'h1;

reg [3:0] cnt;

// a level that differs from dout must persist before it is taken
always @(posedge clk or posedge rst) begin
	if (rst) begin
		cnt  <= 4'h0;
		dout <= 1'h1;
	end else if (din == dout) begin
		cnt <= 4'h0;
	end else if (cnt == LAST) begin
		cnt  <= 4'h0;
		dout <= din;
	end else begin
		cnt <= cnt + 4'h1;
	end
end

endmodule

// File: logic/rtcs_top.v
// Purpose: reset cause tracking, start-up timers and clock-out control
// Assumes: inputs synchronous to clk; rst is the power-on detector
// Notes: osc_in is sampled by clk, so it must stay well below clk/2
// How it works
// - crystal_direct waits 1024 osc_in periods
// - crystal_pll selects 4x pll clock
// - ext_clock_pll selects pll clock too
// - clock_out follows osc_in or osc_in/4
// - five reset causes recorded apart
// - unreset flags keep value on other resets
// - timeout and powerdown flags set per cause
// - master clear glitches are filtered out
// - watchdog reset never drives master clear
// - power-up timer holds reset 72 ms
// - oscillator timer follows power-up timer
// - oscillator timer only crystal, power-on, brown-out, wake
// - brown-out holds, then restarts cleared timer
// - brown-out detection cannot be disabled
// - enable_n high skips power-up delay after brown-out
// - leave reset after last timer, clear high
// - held clear released starts at once
// - brown-out flag cleared by brown-out
// - power-on flag cleared by power-on or a register write of 0
// - delay sums power-up, pll, oscillator terms
// - enable_n low enables power-up delay
// - two-bit field selects the clock mode
`timescale 1ns/1ns
`include "rtcs_defines.vh"
module rtcs_top (
	// clock and power-on reset
	input  wire       clk,
	input  wire       rst,
	// oscillator side
	input  wire       osc_in,
	input  wire       rc_tick,
	output reg        clock_out,
	output reg        clock_out_oe,
	// reset and wake sources
	input  wire       master_clear_n,
	input  wire       brownout_detect,
	input  wire       watchdog_timeout,
	input  wire       interrupt_wake,
	// configuration bits
	input  wire [1:0] clock_source_select,
	input  wire       power_up_timer_enable_n,
	// core side
	output reg        chip_reset,
	output reg        core_run,
	output reg        pll_enable,
	output reg        internal_clock_pll,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata
);

localparam [7:0] S_HOLD  = 8'h01;
localparam [7:0] S_POWER_UP_TIMER  = 8'h02;
localparam [7:0] S_PLL   = 8'h04;
localparam [7:0] S_OST   = 8'h08;
localparam [7:0] S_MASTER_CLEAR_N  = 8'h10;
localparam [7:0] S_RUN   = 8'h20;
localparam [7:0] S_SLEEP = 8'h40;

localparam [1:0] STEP_START     = 2'h0;
localparam [1:0] STEP_AFTER_PWR = 2'h1;
localparam [1:0] STEP_AFTER_PLL = 2'h2;
localparam [1:0] STEP_AFTER_OST = 2'h3;

localparam [31:0] POWER_UP_TIMER_N = `RTCS_POWER_UP_TIMER_TICKS;
localparam [31:0] PLL_N  = `RTCS_PLL_LOCK_TICKS;
localparam [31:0] OST_N  = `RTCS_OST_CYCLES;
localparam [10:0] POWER_UP_TIMER_LAST = POWER_UP_TIMER_N[10:0] - 11'h1;
localparam [10:0] PLL_LAST  = PLL_N[10:0] - 11'h1;
localparam [10:0] OST_LAST  = OST_N[10:0] - 11'h1;

// picks the first timer still due after a given step
function [7:0] seq_next;
	input [1:0] step;
	input       power_up_timer_on;
	input [1:0] md;
	input       to_reset;
	reg   [7:0] s;
	begin
		if (step == STEP_START && power_up_timer_on)
			s = S_POWER_UP_TIMER;
		else if (step != STEP_AFTER_PLL && step != STEP_AFTER_OST &&
		    md[1])
			s = S_PLL;
		else if (step != STEP_AFTER_OST && !md[0])
			s = S_OST;
		else
			s = S_MASTER_CLEAR_N;
		if (s == S_MASTER_CLEAR_N && !to_reset)
			s = S_RUN;
		seq_next = s;
	end
endfunction

reg  [7:0] state;
reg  [10:0] cnt;
reg        seq_reset;
reg  [4:0] cause;
reg        to_n;
reg        pd_n;
reg        por_flag;
reg        bor_flag;
reg        osc_q;
reg        div_ph;
wire       master_clear_n_filt;

reg  [7:0] next_state;
reg  [10:0] next_cnt;
reg        next_seq_reset;
reg  [4:0] next_cause;
reg        next_to_n;
reg        next_pd_n;
reg  [7:0] rd_word;

wire osc_rise = osc_in & ~osc_q;
wire master_clear_n_low = ~master_clear_n_filt;
wire wr_power_control_status  = reg_wr && reg_addr == `RTCS_ADDR_POWER_CONTROL_STATUS;
wire wr_ctrl  = reg_wr && reg_addr == `RTCS_ADDR_CTRL;
wire sleep_cmd  = wr_ctrl && reg_wdata[`RTCS_CTRL_SLEEP_BIT];
wire clrwdt_cmd = wr_ctrl && reg_wdata[`RTCS_CTRL_CLRWDT_BIT];
wire power_up_timer_on  = ~power_up_timer_enable_n;
wire timing   = (state == S_PLL) || (state == S_OST);

rtcs_glitch_filter u_master_clear_n_filter (
	.clk  (clk),
	.rst  (rst),
	.din  (master_clear_n),
	.dout (master_clear_n_filt)
);

// sequencer: brown-out has no enable and overrides every state
always @* begin
	next_state     = state;
	next_cnt       = cnt;
	next_seq_reset = seq_reset;
	next_cause     = cause;
	next_to_n      = to_n;
	next_pd_n      = pd_n;
	if (brownout_detect) begin
		next_state     = S_HOLD;
		next_cnt       = 11'h0;
		next_seq_reset = 1'h1;
		next_cause     = `RTCS_CAUSE_BOR;
		next_to_n      = 1'h1;
		next_pd_n      = 1'h1;
	end else if (master_clear_n_low && !seq_reset && timing) begin
		// clear during a wake turns the wake into a reset
		next_seq_reset = 1'h1;
		next_cause     = `RTCS_CAUSE_MASTER_CLEAR_N_SLEEP;
		next_to_n      = 1'h1;
		next_pd_n      = 1'h0;
	end else begin
		case (state)
		S_HOLD: begin
			next_cnt   = 11'h0;
			next_state = seq_next(STEP_START, power_up_timer_on,
			    clock_source_select, 1'h1);
		end
		S_POWER_UP_TIMER: begin
			if (rc_tick) begin
				if (cnt == POWER_UP_TIMER_LAST) begin
					next_cnt   = 11'h0;
					next_state = seq_next(STEP_AFTER_PWR, power_up_timer_on,
					    clock_source_select, seq_reset);
				end else begin
					next_cnt = cnt + 11'h1;
				end
			end
		end
		S_PLL: begin
			if (rc_tick) begin
				if (cnt == PLL_LAST) begin
					next_cnt   = 11'h0;
					next_state = seq_next(STEP_AFTER_PLL, power_up_timer_on,
					    clock_source_select, seq_reset);
				end else begin
					next_cnt = cnt + 11'h1;
				end
			end
		end
		S_OST: begin
			if (osc_rise) begin
				if (cnt == OST_LAST) begin
					next_cnt   = 11'h0;
					next_state = seq_next(STEP_AFTER_OST, power_up_timer_on,
					    clock_source_select, seq_reset);
				end else begin
					next_cnt = cnt + 11'h1;
				end
			end
		end
		S_MASTER_CLEAR_N: begin
			// timers are done; only the pin holds reset now
			if (!master_clear_n_low) begin
				next_state     = S_RUN;
				next_seq_reset = 1'h0;
			end
		end
		S_RUN: begin
			if (master_clear_n_low) begin
				next_state     = S_MASTER_CLEAR_N;
				next_seq_reset = 1'h1;
				next_cause     = `RTCS_CAUSE_MASTER_CLEAR_N_RUN;
			end else if (watchdog_timeout) begin
				// internal reset only, the clear pin is input only
				next_state     = S_MASTER_CLEAR_N;
				next_seq_reset = 1'h1;
				next_cause     = `RTCS_CAUSE_WDT;
				next_to_n      = 1'h0;
				next_pd_n      = 1'h1;
			end else if (sleep_cmd) begin
				next_state = S_SLEEP;
				next_to_n  = 1'h1;
				next_pd_n  = 1'h0;
			end else if (clrwdt_cmd) begin
				next_to_n = 1'h1;
				next_pd_n = 1'h1;
			end
		end
		S_SLEEP: begin
			next_cnt = 11'h0;
			if (master_clear_n_low) begin
				next_seq_reset = 1'h1;
				next_cause     = `RTCS_CAUSE_MASTER_CLEAR_N_SLEEP;
				next_to_n      = 1'h1;
				next_pd_n      = 1'h0;
				next_state     = seq_next(STEP_AFTER_PWR, 1'h0,
				    clock_source_select, 1'h1);
			end else if (watchdog_timeout) begin
				next_seq_reset = 1'h0;
				next_to_n      = 1'h0;
				next_pd_n      = 1'h0;
				next_state     = seq_next(STEP_AFTER_PWR, 1'h0,
				    clock_source_select, 1'h0);
			end else if (interrupt_wake) begin
				next_seq_reset = 1'h0;
				next_to_n      = 1'h1;
				next_pd_n      = 1'h0;
				next_state     = seq_next(STEP_AFTER_PWR, 1'h0,
				    clock_source_select, 1'h0);
			end
		end
		default: begin
			next_state     = S_HOLD;
			next_cnt       = 11'h0;
			next_seq_reset = 1'h1;
		end
		endcase
	end
end

// rst is the power-on event itself
always @(posedge clk or posedge rst) begin
	if (rst) begin
		state     <= S_HOLD;
		cnt       <= 11'h0;
		seq_reset <= 1'h1;
		cause     <= `RTCS_CAUSE_POR;
		to_n      <= `RTCS_TO_RST;
		pd_n      <= `RTCS_PD_RST;
	end else begin
		state     <= next_state;
		cnt       <= next_cnt;
		seq_reset <= next_seq_reset;
		cause     <= next_cause;
		to_n      <= next_to_n;
		pd_n      <= next_pd_n;
	end
end

// outputs but pll_enable follow the next state so they line up with state
always @(posedge clk or posedge rst) begin
	if (rst) begin
		chip_reset         <= 1'h1;
		core_run           <= 1'h0;
		pll_enable         <= 1'h0;
		internal_clock_pll <= 1'h0;
	end else begin
		chip_reset <= (next_state == S_HOLD) ||
		    (next_state == S_MASTER_CLEAR_N) ||
		    (next_seq_reset && (next_state == S_POWER_UP_TIMER ||
		    next_state == S_PLL || next_state == S_OST));
		core_run   <= next_state == S_RUN;
		pll_enable <= clock_source_select[1];
		// pll output is used only once its lock time has passed
		internal_clock_pll <= clock_source_select[1] &&
		    next_state != S_HOLD && next_state != S_POWER_UP_TIMER &&
		    next_state != S_PLL;
	end
end

// power-on flag: the power-on event or a register write of 0 clears it
always @(posedge clk or posedge rst) begin
	if (rst)
		por_flag <= `RTCS_POR_FLAG_RST;
	else if (wr_power_control_status)
		por_flag <= reg_wdata[`RTCS_POWER_CONTROL_STATUS_POR_BIT];
end

// no reset: unknown after power-on, kept on other resets
always @(posedge clk) begin
	if (brownout_detect)
		bor_flag <= 1'h0;
	else if (wr_power_control_status)
		bor_flag <= reg_wdata[`RTCS_POWER_CONTROL_STATUS_BOR_BIT];
end

// clock out: direct in ext_clock_pll, quarter rate otherwise
always @(posedge clk or posedge rst) begin
	if (rst) begin
		osc_q        <= 1'h0;
		div_ph       <= 1'h0;
		clock_out    <= 1'h0;
		clock_out_oe <= 1'h0;
	end else begin
		osc_q        <= osc_in;
		clock_out_oe <= clock_source_select[0];
		if (clock_source_select == `RTCS_MODE_EXT_PLL) begin
			clock_out <= osc_in;
		end else if (osc_rise) begin
			div_ph <= ~div_ph;
			if (div_ph)
				clock_out <= ~clock_out;
		end
	end
end

// read mux; unmapped offsets read zero
always @* begin
	rd_word = 8'h00;
	case (reg_addr)
	`RTCS_ADDR_POWER_CONTROL_STATUS: begin
		rd_word[`RTCS_POWER_CONTROL_STATUS_POR_BIT] = por_flag;
		rd_word[`RTCS_POWER_CONTROL_STATUS_BOR_BIT] = bor_flag;
	end
	`RTCS_ADDR_STATUS: begin
		rd_word[`RTCS_STAT_TO_BIT]    = to_n;
		rd_word[`RTCS_STAT_PD_BIT]    = pd_n;
		rd_word[`RTCS_STAT_RESET_BIT] = chip_reset;
		rd_word[`RTCS_STAT_RUN_BIT]   = core_run;
	end
	`RTCS_ADDR_CAUSE: begin
		rd_word[4:0] = cause;
	end
	default: begin
		rd_word = 8'h00;
	end
	endcase
end

always @(posedge clk or posedge rst) begin
	if (rst)
		reg_rdata <= 8'h00;
	else if (reg_rd)
		reg_rdata <= rd_word;
	else
		reg_rdata <= 8'h00;
end

endmodule

// File: testbench/rtcs_sva.sv
// Purpose: port checker for the sequencer
// Assumes: one clock domain, rst async high
// Notes: master clear filter is 3 samples
`timescale 1ns/1ns
module rtcs_sva (
	// clock and reset
	input logic       clk,
	input logic       rst,
	// watched ports
	input logic       osc_in,
	input logic       clock_out,
	input logic       clock_out_oe,
	input logic       master_clear_n,
	input logic       brownout_detect,
	input logic       watchdog_timeout,
	input logic [1:0] clock_source_select,
	input logic       chip_reset,
	input logic       core_run,
	input logic       pll_enable,
	input logic [7:0] reg_addr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_blip;
		core_run && !master_clear_n && $past(master_clear_n) &&
		!watchdog_timeout && !brownout_detect ##1
		master_clear_n && !watchdog_timeout && !brownout_detect;
	endsequence
	sequence s_hold;
		core_run && $fell(master_clear_n) ##1 !master_clear_n [*2];
	endsequence
	sequence s_dog;
		core_run && watchdog_timeout && master_clear_n &&
		!brownout_detect ##1 master_clear_n && !brownout_detect;
	endsequence
	property p_blip;
		s_blip |-> !chip_reset [*2];
	endproperty
	property p_hold;
		s_hold |-> ##[1:3] chip_reset;
	endproperty
	property p_dog;
		s_dog |-> chip_reset && !core_run ##1 !chip_reset;
	endproperty
	property p_bod;
		brownout_detect |=> chip_reset && !core_run;
	endproperty
	property p_oe;
		!$past(rst) |-> clock_out_oe == $past(clock_source_select[0]);
	endproperty
	property p_pll;
		!$past(rst) |-> pll_enable == $past(clock_source_select[1]);
	endproperty
	property p_ck;
		clock_source_select == 2'h3 && $past(clock_source_select) == 2'h3
		&& !$past(rst) |-> clock_out == $past(osc_in);
	endproperty
	property p_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	property p_cause;
		reg_rd && reg_addr == 8'h0c |=>
		$onehot(reg_rdata[4:0]) && reg_rdata[7:5] == 3'h0;
	endproperty
	a_blip: assert property (p_blip) else $error("glitch reset");
	a_hold: assert property (p_hold) else $error("clear ignored");
	a_dog: assert property (p_dog) else $error("watchdog pulse");
	a_bod: assert property (p_bod) else $error("brownout");
	a_oe: assert property (p_oe) else $error("clock out enable");
	a_pll: assert property (p_pll) else $error("pll enable");
	a_ck: assert property (p_ck) else $error("clock out follow");
	a_idle: assert property (p_idle) else $error("rdata not idle");
	a_cause: assert property (p_cause) else $error("cause not one");
endmodule
bind rtcs_top rtcs_sva chk_u (.clk, .rst, .osc_in, .clock_out,
	.clock_out_oe, .master_clear_n, .brownout_detect, .watchdog_timeout,
	.clock_source_select, .chip_reset, .core_run, .pll_enable, .reg_addr,
	.reg_rd, .reg_rdata);

// File: testbench/rtcs_osc_model.sv
// Purpose: oscillator and rc tick source
// Assumes: osc_in at clk/8, rc_tick every 10 clk
// Notes: both run free, like a powered crystal and rc cell
`timescale 1ns/1ns
module rtcs_osc_model (
	// clock
	input  logic clk,
	// sources
	output logic osc_in,
	output logic rc_tick
);
	logic [3:0] oc = 4'h0;
	logic [3:0] tc = 4'h0;
	always @(posedge clk) begin
		oc <= oc + 4'h1;
		tc <= (tc == 4'h9) ? 4'h0 : tc + 4'h1;
		osc_in <= oc[2];
		rc_tick <= (tc == 4'h9);
	end
endmodule

// File: testbench/rtcs_bench.sv
// Purpose: self-checking run of the sequencer
// Assumes: osc_in at clk/8, rc_tick every 10 clk
// Notes: delays are windows since tick phase is free
`timescale 1ns/1ns
module rtcs_bench;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       mcn = 1'b1;
	logic       bod = 1'b0;
	logic       wdt = 1'b0;
	logic       iw  = 1'b0;
	logic [1:0] sel = 2'h1;
	logic       en  = 1'b1;
	logic [7:0] ad  = 8'h00;
	logic [7:0] wd  = 8'h00;
	logic       wr  = 1'b0;
	logic       rd  = 1'b0;
	wire        osc, tick, co, coe, crst, run, pll, ipll;
	wire  [7:0] rdat;
	int         miscompares = 0;
	int         comparisons = 0;
	int         cyc = 0;
	int         d;
	always #50 clk = ~clk;
	rtcs_osc_model src_u (.clk(clk), .osc_in(osc), .rc_tick(tick));
	rtcs_top dut_u (.clk(clk), .rst(rst), .osc_in(osc), .rc_tick(tick),
		.clock_out(co), .clock_out_oe(coe), .master_clear_n(mcn),
		.brownout_detect(bod), .watchdog_timeout(wdt),
		.interrupt_wake(iw), .clock_source_select(sel),
		.power_up_timer_enable_n(en), .chip_reset(crst), .core_run(run),
		.pll_enable(pll), .internal_clock_pll(ipll), .reg_addr(ad),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
	task finish_test;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmp(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task rng(string n, int lo, int hi, int g);
		comparisons++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, g);
		end
	endtask
	task cyc_n(int n);
		repeat (n) @(posedge clk);
	endtask
	task wr_r(logic [7:0] a, logic [7:0] v);
		ad <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// the brownout flag has no reset value, so callers mask it
	task chk(logic [7:0] a, logic [7:0] m, logic [7:0] e);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp($sformatf("reg %h", a), e, rdat & m);
	endtask
	task wait_run;
		d = 0;
		while (run !== 1'b1 && d < 20000) begin
			@(posedge clk);
			#1;
			d++;
		end
	endtask
	task boot(logic [1:0] s, logic e);
		rst <= 1'b1;
		sel <= s;
		en <= e;
		cyc_n(12);
		rst <= 1'b0;
		wait_run();
	endtask
	// which: 0 watchdog, 1 interrupt wake, 2 brown-out; high n cycles
	task pulse(int which, int n);
		case (which)
		0: wdt <= 1'b1;
		1: iw <= 1'b1;
		default: bod <= 1'b1;
		endcase
		cyc_n(n);
		wdt <= 1'b0;
		iw  <= 1'b0;
		bod <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			finish_test();
		end
	end
	logic [1:0] ms [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
	logic       es [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	int         lo [5] = '{2, 31, 11, 8184, 8224};
	int         hi [5] = '{2, 44, 24, 8198, 8260};
	initial begin
		int t;
		logic p;
		for (int i = 0; i < 5; i++) begin
			boot(ms[i], es[i]);
			rng("delay", lo[i], hi[i], d);
			cmp("ipll", ms[i][1], ipll);
			chk(8'h0c, 8'hff, 8'h01);
			chk(8'h04, 8'hff, 8'h19);
			chk(8'h00, 8'h02, 8'h00);
			t = 0;
			p = co;
			repeat (256) begin
				@(posedge clk);
				#1;
				t += (co !== p);
				p = co;
			end
			rng("toggles", ms[i] == 2'h3 ? 63 : 15, ms[i] == 2'h3 ? 65 : 17, t);
		end
		boot(2'h1, 1'b1);
		wr_r(8'h00, 8'h03);
		chk(8'h00, 8'hff, 8'h03);
		mcn <= 1'b0;
		cyc_n(1);
		mcn <= 1'b1;
		cyc_n(4);
		cmp("blip", 8'h01, run);
		mcn <= 1'b0;
		cyc_n(2);
		mcn <= 1'b1;
		cyc_n(4);
		cmp("glitch", 8'h01, run);
		mcn <= 1'b0;
		cyc_n(5);
		mcn <= 1'b1;
		wait_run();
		chk(8'h0c, 8'hff, 8'h02);
		chk(8'h04, 8'hff, 8'h19);
		chk(8'h00, 8'hff, 8'h03);
		pulse(0, 1);
		wait_run();
		chk(8'h0c, 8'hff, 8'h08);
		chk(8'h04, 8'hff, 8'h09);
		wr_r(8'h08, 8'h02);
		chk(8'h04, 8'hff, 8'h19);
		wr_r(8'h08, 8'h01);
		chk(8'h04, 8'hff, 8'h10);
		pulse(0, 1);
		wait_run();
		chk(8'h04, 8'hff, 8'h01);
		wr_r(8'h08, 8'h01);
		pulse(1, 1);
		wait_run();
		chk(8'h04, 8'hff, 8'h11);
		wr_r(8'h08, 8'h01);
		mcn <= 1'b0;
		cyc_n(5);
		mcn <= 1'b1;
		wait_run();
		chk(8'h0c, 8'hff, 8'h04);
		chk(8'h04, 8'hff, 8'h11);
		pulse(2, 3);
		wait_run();
		rng("bor fast", 1, 4, d);
		chk(8'h00, 8'hff, 8'h02);
		chk(8'h0c, 8'hff, 8'h10);
		en <= 1'b0;
		pulse(2, 2);
		cyc_n(20);
		pulse(2, 2);
		wait_run();
		rng("bor restart", 31, 46, d);
		rst <= 1'b1;
		mcn <= 1'b0;
		cyc_n(12);
		rst <= 1'b0;
		cyc_n(100);
		cmp("held", 8'h01, crst);
		mcn <= 1'b1;
		wait_run();
		rng("release", 3, 5, d);
		wr_r(8'h04, 8'hff);
		chk(8'h04, 8'hff, 8'h19);
		chk(8'h10, 8'hff, 8'h00);
		chk(8'h0c, 8'hff, 8'h01);
		chk(8'h00, 8'h02, 8'h00);
		finish_test();
	end
endmodule
